// ---- src/ccd_pkg.sv ----
// Constants for the reset configuration clock decoder.
// Assumes a 32-bit AXI4-Lite master and a single 50 MHz clock.
package ccd_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CFG_LO  = 8'h00;
    localparam logic [7:0] OFS_CFG_HI  = 8'h04;
    localparam logic [7:0] OFS_CTRL    = 8'h08;
    localparam logic [7:0] OFS_RATIOS  = 8'h0C;
    localparam logic [7:0] OFS_SELECTS = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;
    // Configuration word low: field positions
    localparam int MEM_CFG_LSB   = 8;
    localparam int MEM_RAT_LSB   = 10;
    localparam int PLAT_RAT_LSB  = 16;
    localparam int PLAT_CFG_LSB  = 21;
    localparam int MEMREF_BIT    = 23;
    localparam int CL1_RAT_LSB   = 24;
    localparam int CL1_CFG_LSB   = 30;
    // Configuration word high: field positions
    localparam int CL2_RAT_LSB   = 0;
    localparam int CL2_CFG_LSB   = 6;
    localparam int CL1_SEL_LSB   = 8;
    localparam int CL2_SEL_LSB   = 12;
    localparam int SD_SEL_LSB    = 16;
    localparam int LANE_REF_BIT  = 19;
    localparam int LANE_DIV_LSB  = 20;
    localparam int LANE_PROT_LSB = 22;
    // Reset values of the configuration words
    localparam logic [31:0] CFG_LO_RST = 32'h0000_0000;
    localparam logic [31:0] CFG_HI_RST = 32'h0000_0000;
    // Lane protocol classes
    localparam logic [2:0] PROT_PCIE   = 3'h0;
    localparam logic [2:0] PROT_SATA   = 3'h1;
    localparam logic [2:0] PROT_SGMII  = 3'h2;
    localparam logic [2:0] PROT_QSGMII = 3'h3;
    localparam logic [2:0] PROT_DEBUG  = 3'h4;
    localparam logic [2:0] PROT_SG3G   = 3'h5;
    localparam logic [2:0] PROT_XFI    = 3'h6;
    // Lane rate codes, in 100 Mbps units
    localparam logic [7:0] RATE_2G5 = 8'h19;
    localparam logic [7:0] RATE_3G0 = 8'h1E;
    localparam logic [7:0] RATE_5G0 = 8'h32;
    // Lane reference codes, in 10 kHz units
    localparam logic [15:0] REF_100M = 16'h2710;
    localparam logic [15:0] REF_125M = 16'h30D4;
    localparam logic [15:0] REF_156M = 16'h3D09;
    // Memory bus clock divider: toggle every half of memory PLL period
    localparam logic [1:0] MEM_CLK_DIV = 2'h1;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- src/ccd_decoder.sv ----
// Reset configuration word clock field decoder with AXI4-Lite access.
// Assumes one 50 MHz clock; the memory bus clock output is a divided
// enable-derived toggle, standing in for the independent memory PLL.
module ccd_decoder (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    // Power-on strap and configuration hold
    input  wire logic        primary_refclk_select_strap_i,
    input  wire logic        por_hold_i,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  s_awaddr_i,
    input  wire logic        s_awvalid_i,
    output logic             s_awready_o,
    input  wire logic [31:0] s_wdata_i,
    input  wire logic [3:0]  s_wstrb_i,
    input  wire logic        s_wvalid_i,
    output logic             s_wready_o,
    // AXI4-Lite write response
    output logic [1:0]       s_bresp_o,
    output logic             s_bvalid_o,
    input  wire logic        s_bready_i,
    // AXI4-Lite read
    input  wire logic [7:0]  s_araddr_i,
    input  wire logic        s_arvalid_i,
    output logic             s_arready_o,
    output logic [31:0]      s_rdata_o,
    output logic [1:0]       s_rresp_o,
    output logic             s_rvalid_o,
    input  wire logic        s_rready_i,
    // Decoded clock outputs
    output logic [4:0]       platform_mult_o,
    output logic [4:0]       cluster1_mult_o,
    output logic [4:0]       cluster2_mult_o,
    output logic [4:0]       memory_mult_o,
    output logic [2:0]       sd_host_div_o,
    output logic             platform_pll_en_o,
    output logic             cluster_pll_en_o,
    output logic             memory_pll_en_o,
    output logic             memory_refclk_select_o,
    output logic             primary_refclk_diff_o,
    output logic             memory_bus_clock_out_o,
    output logic             config_error_o
);

    // Reset synchroniser
    logic rst_q1;
    logic rst_n;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // Strap and hold synchronisers
    logic [1:0] strap_q;
    logic [1:0] hold_q;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            strap_q <= 2'h0;
            hold_q  <= 2'h0;
        end else begin
            strap_q <= {strap_q[0], primary_refclk_select_strap_i};
            hold_q  <= {hold_q[0], por_hold_i};
        end
    end

    // Field decode functions
    function automatic logic [4:0] dec_plat(input logic [4:0] c);
        dec_plat = (c >= 5'h03 && c <= 5'h09) ? c : 5'h00;
    endfunction

    function automatic logic [4:0] dec_cluster(input logic [5:0] c);
        logic [4:0] r;
        r = 5'h00;
        if (c >= 6'h06 && c <= 6'h10)
            r = c[4:0];
        else if (c == 6'h12 || c == 6'h14 || c == 6'h16 ||
                 c == 6'h19 || c == 6'h1A || c == 6'h1B)
            r = c[4:0];
        dec_cluster = r;
    endfunction

    function automatic logic [4:0] dec_mem(input logic [5:0] c);
        logic [4:0] r;
        r = 5'h00;
        if (c == 6'h08 || (c >= 6'h0A && c <= 6'h10) ||
            c == 6'h14 || c == 6'h18)
            r = c[4:0];
        dec_mem = r;
    endfunction

    // Register file and bus state
    logic [31:0] cfg_lo;
    logic [31:0] cfg_hi;
    logic        ctrl_hold;
    logic [31:0] next_cfg_lo;
    logic [31:0] next_cfg_hi;
    logic        next_ctrl_hold;
    logic        aw_got, w_got, next_aw_got, next_w_got;
    logic [7:0]  aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0]  w_strb, next_w_strb;
    logic        bvalid, next_bvalid;
    logic [1:0]  bresp, next_bresp;
    logic        rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0]  rresp, next_rresp;

    // Decoded values
    logic [4:0] plat_m, cl1_m, cl2_m, mem_m;
    logic [2:0] sd_div, sd_sel;
    logic       sel_bad, err;
    logic [2:0] lane_prot;
    logic       lane_ref;
    logic [1:0] lane_div;
    logic [15:0] lane_ref_khz;
    logic [7:0]  lane_rate;

    always_comb begin
        plat_m = dec_plat(cfg_lo[ccd_pkg::PLAT_RAT_LSB +: 5]);
        cl1_m  = dec_cluster(cfg_lo[ccd_pkg::CL1_RAT_LSB +: 6]);
        cl2_m  = dec_cluster(cfg_hi[ccd_pkg::CL2_RAT_LSB +: 6]);
        mem_m  = dec_mem(cfg_lo[ccd_pkg::MEM_RAT_LSB +: 6]);
        // Cluster select accepts only /1 and /2
        sel_bad = (cfg_hi[ccd_pkg::CL1_SEL_LSB +: 4] > 4'h1) ||
                  (cfg_hi[ccd_pkg::CL2_SEL_LSB +: 4] > 4'h1);
        // SD host select 1..4 is the divisor itself
        sd_sel = cfg_hi[ccd_pkg::SD_SEL_LSB +: 3];
        sd_div = (sd_sel >= 3'h1 && sd_sel <= 3'h4) ? sd_sel : 3'h0;
        err = (plat_m == 5'h00) || (cl1_m == 5'h00) ||
              (cl2_m == 5'h00) || (mem_m == 5'h00) ||
              sel_bad || (sd_div == 3'h0);
    end

    // Lane reference and rate decode
    always_comb begin
        lane_prot = cfg_hi[ccd_pkg::LANE_PROT_LSB +: 3];
        lane_ref  = cfg_hi[ccd_pkg::LANE_REF_BIT];
        lane_div  = cfg_hi[ccd_pkg::LANE_DIV_LSB +: 2];
        lane_ref_khz = lane_ref ? ccd_pkg::REF_125M :
                                  ccd_pkg::REF_100M;
        if (lane_prot == ccd_pkg::PROT_SG3G && !lane_ref)
            lane_ref_khz = ccd_pkg::REF_125M;
        if (lane_prot == ccd_pkg::PROT_XFI && !lane_ref)
            lane_ref_khz = ccd_pkg::REF_156M;
        case (lane_prot)
            ccd_pkg::PROT_PCIE:   lane_rate =
                (lane_div == 2'h2) ? ccd_pkg::RATE_2G5 :
                (lane_div == 2'h1) ? ccd_pkg::RATE_5G0 : 8'h00;
            ccd_pkg::PROT_DEBUG:  lane_rate = lane_div[0] ?
                ccd_pkg::RATE_2G5 : ccd_pkg::RATE_5G0;
            ccd_pkg::PROT_QSGMII: lane_rate = lane_div[0] ? 8'h00 :
                ccd_pkg::RATE_5G0;
            ccd_pkg::PROT_SATA:   lane_rate = ccd_pkg::RATE_3G0;
            default:     lane_rate = 8'h00; // Divider ignored
        endcase
    end

    // Bus next-state logic; configuration frozen while ctrl_hold is set
    always_comb begin
        next_cfg_lo    = cfg_lo;
        next_cfg_hi    = cfg_hi;
        next_ctrl_hold = ctrl_hold;
        next_aw_got    = aw_got;
        next_w_got     = w_got;
        next_aw_addr   = aw_addr;
        next_w_data    = w_data;
        next_w_strb    = w_strb;
        next_bvalid    = bvalid;
        next_bresp     = bresp;
        next_rvalid    = rvalid;
        next_rdata     = rdata;
        next_rresp     = rresp;
        if (s_awvalid_i && !aw_got) begin
            next_aw_got  = 1'b1;
            next_aw_addr = s_awaddr_i;
        end
        if (s_wvalid_i && !w_got) begin
            next_w_got  = 1'b1;
            next_w_data = s_wdata_i;
            next_w_strb = s_wstrb_i;
        end
        if (aw_got && w_got && !bvalid) begin
            next_aw_got = 1'b0;
            next_w_got  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = ccd_pkg::RESP_OKAY;
            case (aw_addr)
                ccd_pkg::OFS_CFG_LO: begin
                    for (int i = 0; i < 4; i++)
                        if (w_strb[i] && !ctrl_hold)
                            next_cfg_lo[8*i +: 8] = w_data[8*i +: 8];
                end
                ccd_pkg::OFS_CFG_HI: begin
                    for (int i = 0; i < 4; i++)
                        if (w_strb[i] && !ctrl_hold)
                            next_cfg_hi[8*i +: 8] = w_data[8*i +: 8];
                end
                ccd_pkg::OFS_CTRL: begin
                    if (w_strb[0])
                        next_ctrl_hold = w_data[0];
                end
                ccd_pkg::OFS_RATIOS, ccd_pkg::OFS_SELECTS,
                ccd_pkg::OFS_STATUS: next_bresp = ccd_pkg::RESP_OKAY;
                default: next_bresp = ccd_pkg::RESP_SLVERR;
            endcase
        end
        if (bvalid && s_bready_i)
            next_bvalid = 1'b0;
        if (s_arvalid_i && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = ccd_pkg::RESP_OKAY;
            case (s_araddr_i)
                ccd_pkg::OFS_CFG_LO:  next_rdata = cfg_lo;
                ccd_pkg::OFS_CFG_HI:  next_rdata = cfg_hi;
                ccd_pkg::OFS_CTRL:    next_rdata = {31'h0, ctrl_hold};
                ccd_pkg::OFS_RATIOS:  next_rdata = {12'h0, plat_m, cl1_m,
                                                    cl2_m, mem_m};
                ccd_pkg::OFS_SELECTS: next_rdata = {lane_ref_khz, lane_rate,
                                                    5'h0, sd_div};
                ccd_pkg::OFS_STATUS:  next_rdata = {29'h0, strap_q[1],
                                        cfg_lo[ccd_pkg::MEMREF_BIT], err};
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = ccd_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid && s_rready_i) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            cfg_lo    <= ccd_pkg::CFG_LO_RST;
            cfg_hi    <= ccd_pkg::CFG_HI_RST;
            ctrl_hold <= 1'b0;
            aw_got    <= 1'b0;
            w_got     <= 1'b0;
            aw_addr   <= 8'h00;
            w_data    <= 32'h0;
            w_strb    <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= 2'h0;
            rvalid    <= 1'b0;
            rdata     <= 32'h0;
            rresp     <= 2'h0;
        end else begin
            cfg_lo    <= next_cfg_lo;
            cfg_hi    <= next_cfg_hi;
            ctrl_hold <= next_ctrl_hold | hold_q[1];
            aw_got    <= next_aw_got;
            w_got     <= next_w_got;
            aw_addr   <= next_aw_addr;
            w_data    <= next_w_data;
            w_strb    <= next_w_strb;
            bvalid    <= next_bvalid;
            bresp     <= next_bresp;
            rvalid    <= next_rvalid;
            rdata     <= next_rdata;
            rresp     <= next_rresp;
        end
    end

    // Memory bus clock: toggles once every two mclk cycles while the memory ratio is valid, a quarter of the mclk rate
    logic [1:0] mdiv, next_mdiv;
    logic       mclk_out, next_mclk_out;
    always_comb begin
        next_mdiv     = mdiv + 2'h1;
        next_mclk_out = mclk_out;
        if (mdiv == ccd_pkg::MEM_CLK_DIV) begin
            next_mdiv = 2'h0;
            if (mem_m != 5'h00)
                next_mclk_out = ~mclk_out;
        end
    end

    // Registered decoded outputs
    logic [4:0] plat_q, cl1_q, cl2_q, mem_q;
    logic [2:0] sd_q;
    logic       pen_q, cen_q, men_q, mref_q, pdiff_q, err_q;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            mdiv     <= 2'h0;
            mclk_out <= 1'b0;
            plat_q   <= 5'h00;
            cl1_q    <= 5'h00;
            cl2_q    <= 5'h00;
            mem_q    <= 5'h00;
            sd_q     <= 3'h0;
            pen_q    <= 1'b0;
            cen_q    <= 1'b0;
            men_q    <= 1'b0;
            mref_q   <= 1'b0;
            pdiff_q  <= 1'b0;
            err_q    <= 1'b0;
        end else begin
            mdiv     <= next_mdiv;
            mclk_out <= next_mclk_out;
            plat_q   <= plat_m;
            cl1_q    <= cl1_m;
            cl2_q    <= cl2_m;
            mem_q    <= mem_m;
            sd_q     <= sd_div;
            pen_q    <= (plat_m != 5'h00);
            cen_q    <= (cl1_m != 5'h00) && (cl2_m != 5'h00)
                        && !sel_bad;
            men_q    <= (mem_m != 5'h00);
            mref_q   <= cfg_lo[ccd_pkg::MEMREF_BIT];
            pdiff_q  <= strap_q[1];
            err_q    <= err;
        end
    end

    // Port drive
    assign s_awready_o            = !aw_got;
    assign s_wready_o             = !w_got;
    assign s_bvalid_o             = bvalid;
    assign s_bresp_o              = bresp;
    assign s_arready_o            = !rvalid;
    assign s_rvalid_o             = rvalid;
    assign s_rdata_o              = rdata;
    assign s_rresp_o              = rresp;
    assign platform_mult_o        = plat_q;
    assign cluster1_mult_o        = cl1_q;
    assign cluster2_mult_o        = cl2_q;
    assign memory_mult_o          = mem_q;
    assign sd_host_div_o          = sd_q;
    assign platform_pll_en_o      = pen_q;
    assign cluster_pll_en_o       = cen_q;
    assign memory_pll_en_o        = men_q;
    assign memory_refclk_select_o = mref_q;
    assign primary_refclk_diff_o  = pdiff_q;
    assign memory_bus_clock_out_o = mclk_out;
    assign config_error_o         = err_q;

endmodule

// ---- dv/ccd_cfg_source.sv ----
// Configuration word source standing in front of the clock decoder.
// Combinational; the bench lets its words settle before each write.
module ccd_cfg_source (
    // Field choices
    input  wire logic [5:0]  code_i,
    input  wire logic [31:0] rnd_i,
    input  wire logic [2:0]  prot_i,
    input  wire logic [1:0]  div_i,
    input  wire logic        ref_i,
    // Configuration words
    output logic      [31:0] cfg_lo_o,
    output logic      [31:0] cfg_hi_o
);
    // PLL config fields stay zero; ratios and selects may be reserved
    always_comb begin
        // Words stand for a 100 MHz single source within rate limits
        // no spread lane reference
        cfg_lo_o = 32'h0000_0000;
        cfg_lo_o[ccd_pkg::MEM_RAT_LSB +: 6] = code_i;
        cfg_lo_o[ccd_pkg::PLAT_RAT_LSB +: 5] = code_i[4:0];
        cfg_lo_o[ccd_pkg::MEMREF_BIT] = rnd_i[0];
        cfg_lo_o[ccd_pkg::CL1_RAT_LSB +: 6] = code_i;
        cfg_hi_o = 32'h0000_0000;
        cfg_hi_o[ccd_pkg::CL2_RAT_LSB +: 6] = rnd_i[5:0];
        cfg_hi_o[ccd_pkg::CL1_SEL_LSB +: 4] = {2'h0, rnd_i[7:6]};
        cfg_hi_o[ccd_pkg::CL2_SEL_LSB +: 4] = {3'h0, rnd_i[12]};
        cfg_hi_o[ccd_pkg::SD_SEL_LSB +: 3] = rnd_i[15:13];
        cfg_hi_o[ccd_pkg::LANE_REF_BIT] = ref_i;
        cfg_hi_o[ccd_pkg::LANE_DIV_LSB +: 2] = div_i;
        cfg_hi_o[ccd_pkg::LANE_PROT_LSB +: 3] = prot_i;
    end
endmodule

// ---- dv/ccd_decoder_asserts.sv ----
// Port-level checker for the clock decoder, bound to its top module.
// Assumes one clock and the raw asynchronous active-low reset.
module ccd_decoder_asserts (
    // Clock, reset and strap
    input wire logic        mclk_i,
    input wire logic        rstn_i,
    input wire logic        primary_refclk_select_strap_i,
    // Write channels
    input wire logic [7:0]  s_awaddr_i,
    input wire logic        s_awvalid_i,
    input wire logic        s_awready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0]  s_wstrb_i,
    input wire logic        s_wvalid_i,
    input wire logic        s_wready_o,
    // Decoded outputs
    input wire logic [4:0]  platform_mult_o,
    input wire logic [4:0]  cluster1_mult_o,
    input wire logic [4:0]  cluster2_mult_o,
    input wire logic [4:0]  memory_mult_o,
    input wire logic [2:0]  sd_host_div_o,
    input wire logic        platform_pll_en_o,
    input wire logic        memory_pll_en_o,
    input wire logic        memory_refclk_select_o,
    input wire logic        primary_refclk_diff_o,
    input wire logic        memory_bus_clock_out_o,
    input wire logic        config_error_o
);
    logic [3:0] up;
    logic [3:0] next_up;
    // Cycles since release; outputs lag the reset synchroniser
    always_comb next_up = (up == 4'hF) ? up : up + 4'h1;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) up <= 4'h0;
        else up <= next_up;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    function automatic logic cl_ok(input logic [4:0] m);
        return m inside {5'h00, [5'h06:5'h10], 5'h12, 5'h14, 5'h16,
                         [5'h19:5'h1B]};
    endfunction
    // Low-word write with byte lane 2 strobed and both channels taken together
    sequence lo_wr_s;
        s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o &&
        s_awaddr_i == ccd_pkg::OFS_CFG_LO && s_wstrb_i[2];
    endsequence
    // Bus clock edge seen while the memory ratio is valid
    sequence bus_edge_s;
        memory_pll_en_o [*2] ##0 $changed(memory_bus_clock_out_o);
    endsequence
    plat_map_a: assert property (
        platform_pll_en_o == (platform_mult_o inside {[5'h03:5'h09]}))
        else $error("platform multiplier outside its table");
    clus_map_a: assert property (
        cl_ok(cluster1_mult_o) && cl_ok(cluster2_mult_o))
        else $error("cluster multiplier outside its table");
    mem_map_a: assert property (
        memory_pll_en_o == (memory_mult_o != 5'h00) && memory_mult_o
        inside {5'h00, 5'h08, [5'h0A:5'h10], 5'h14, 5'h18})
        else $error("memory multiplier outside its table");
    sd_div_a: assert property (sd_host_div_o <= 3'h4)
        else $error("sd divisor above four");
    cfg_err_a: assert property (
        up == 4'hF && (platform_mult_o == 5'h00 || memory_mult_o == 5'h00
        || cluster1_mult_o == 5'h00 || cluster2_mult_o == 5'h00
        || sd_host_div_o == 3'h0) |-> config_error_o)
        else $error("reserved field without config error");
    bus_clk_a: assert property (
        bus_edge_s |=> !memory_pll_en_o or ($stable(memory_bus_clock_out_o)
        ##1 (!memory_pll_en_o or $changed(memory_bus_clock_out_o))))
        else $error("memory bus clock not toggling every two cycles");
    strap_sel_a: assert property (
        $rose(primary_refclk_select_strap_i) |-> ##[2:6] primary_refclk_diff_o)
        else $error("primary reference select not followed");
    memref_sel_a: assert property (
        lo_wr_s |-> ##3 memory_refclk_select_o ==
        $past(s_wdata_i[ccd_pkg::MEMREF_BIT], 3))
        else $error("memory reference select not followed");
endmodule

bind ccd_decoder ccd_decoder_asserts u_chk (.*);

// ---- dv/ccd_decoder_tb.sv ----
// Self-checking bench for the clock decoder over AXI4-Lite.
// Assumes the partner source builds every configuration word.
module ccd_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin failures++; \
$display("CHECK FAILED %0t %s", $time, m); end end
    typedef struct { logic [31:0] d; logic [31:0] m; logic [1:0] r; } ccd_exp_s;
    logic        mclk = 1'b0;
    logic        rstn, strap, awv, wv, bready, arv, rready, rsel;
    logic        awr, wrdy, bv, arr, rv, p_en, c_en, m_en, mref, pdiff, mck, err;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rnd, lo, hi, old;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, div;
    logic [4:0]  pm, c1m, c2m, mm, pe, c1e, c2e, me;
    logic [2:0]  sdd, sde, prot;
    logic [5:0]  code;
    int          failures, n_checks;
    ccd_exp_s    q[$];
    logic [2:0]  tp[8]  = '{3'h0, 3'h0, 3'h1, 3'h4, 3'h4, 3'h3, 3'h5, 3'h6};
    logic [1:0]  tdv[8] = '{2'h2, 2'h1, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0};
    logic        trf[8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    logic [23:0] tex[8] = '{{ccd_pkg::REF_100M, ccd_pkg::RATE_2G5},
        {ccd_pkg::REF_125M, ccd_pkg::RATE_5G0},
        {ccd_pkg::REF_100M, ccd_pkg::RATE_3G0},
        {ccd_pkg::REF_125M, ccd_pkg::RATE_2G5},
        {ccd_pkg::REF_100M, ccd_pkg::RATE_5G0},
        {ccd_pkg::REF_125M, ccd_pkg::RATE_5G0},
        {ccd_pkg::REF_125M, 8'h00}, {ccd_pkg::REF_156M, 8'h00}};
    // Free-running 50 MHz clock
    always #10 mclk = ~mclk;
    ccd_decoder DUT (.mclk_i(mclk), .rstn_i(rstn),
        .primary_refclk_select_strap_i(strap), .por_hold_i(1'b0),
        .s_awaddr_i(awaddr), .s_awvalid_i(awv), .s_awready_o(awr),
        .s_wdata_i(wdata), .s_wstrb_i(wstrb), .s_wvalid_i(wv),
        .s_wready_o(wrdy), .s_bresp_o(bresp), .s_bvalid_o(bv),
        .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arv),
        .s_arready_o(arr), .s_rdata_o(rdata), .s_rresp_o(rresp),
        .s_rvalid_o(rv), .s_rready_i(rready), .platform_mult_o(pm),
        .cluster1_mult_o(c1m), .cluster2_mult_o(c2m), .memory_mult_o(mm),
        .sd_host_div_o(sdd), .platform_pll_en_o(p_en),
        .cluster_pll_en_o(c_en), .memory_pll_en_o(m_en),
        .memory_refclk_select_o(mref), .primary_refclk_diff_o(pdiff),
        .memory_bus_clock_out_o(mck), .config_error_o(err));
    ccd_cfg_source u_src (.code_i(code), .rnd_i(rnd), .prot_i(prot),
        .div_i(div), .ref_i(rsel), .cfg_lo_o(lo), .cfg_hi_o(hi));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [4:0] cl_x(input logic [5:0] c);
        return (c inside {[6'h06:6'h10], 6'h12, 6'h14, 6'h16, [6'h19:6'h1B]})
            ? c[4:0] : 5'h00;
    endfunction
    task automatic end_of_test();
        if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Write: both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        for (int k = 0; k < 64 && !tb; k++) begin
            @(negedge mclk);
            ta = awv & awr;
            tw = wv & wrdy;
            tb = (bv === 1'b1);
            if (tb) `CHK(bresp, ccd_pkg::RESP_OKAY, "bresp")
            @(posedge mclk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end
        bready <= 1'b0;
        if (!tb) begin failures++; end_of_test(); end
    endtask
    // Read: the expected word is noted for the monitor
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic [1:0] r);
        logic ta, t;
        @(posedge mclk);
        q.push_back('{d, m, r});
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        t = 1'b0;
        for (int k = 0; k < 64 && !t; k++) begin
            @(negedge mclk);
            ta = arv & arr;
            t = (rv === 1'b1);
            @(posedge mclk);
            if (ta) arv <= 1'b0;
        end
        rready <= 1'b0;
        if (!t) begin failures++; end_of_test(); end
    endtask
    // Decoded outputs against the expectations of the last write
    task automatic chk_out();
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        `CHK(pm, pe, "platform")
        `CHK(c1m, c1e, "cluster one")
        `CHK(c2m, c2e, "cluster two")
        `CHK(mm, me, "memory")
        `CHK(sdd, sde, "sd divisor")
        `CHK(mref, lo[ccd_pkg::MEMREF_BIT], "memory reference")
        `CHK(p_en, (pe != 5'h00), "platform enable")
        `CHK(c_en, (c1e != 5'h00 && c2e != 5'h00 && !rnd[7]),
             "cluster enable")
        `CHK(m_en, (me != 5'h00), "memory enable")
        `CHK(err, (pe == 5'h00 || c1e == 5'h00 || c2e == 5'h00 || me == 5'h00
             || sde == 3'h0 || rnd[7]), "config error")
    endtask
    // Monitor: each read answer takes the oldest note
    always @(negedge mclk) begin
        if (rv === 1'b1 && rready === 1'b1) begin
            if (q.size() == 0) `CHK(1'b1, 1'b0, "unexpected read")
            else begin
                `CHK(rdata & q[0].m, q[0].d & q[0].m, "rdata")
                `CHK(rresp, q[0].r, "rresp")
                void'(q.pop_front());
            end
        end
    end
    // Main sequence
    initial begin
        {rstn, strap, awv, wv, bready, arv, rready, rsel, div, prot} = '0;
        {awaddr, araddr, wdata, code} = '0;
        wstrb = 4'hF;
        rnd = 32'h98215841;
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        `CHK(err, 1'b1, "reset config error")
        rd(ccd_pkg::OFS_CFG_LO, ccd_pkg::CFG_LO_RST, 32'hFFFF_FFFF, 2'h0);
        rd(ccd_pkg::OFS_CFG_HI, ccd_pkg::CFG_HI_RST, 32'hFFFF_FFFF, 2'h0);
        strap <= 1'b1;
        repeat (8) @(posedge mclk);
        rd(ccd_pkg::OFS_STATUS, 32'h4, 32'h4, ccd_pkg::RESP_OKAY);
        `CHK(pdiff, 1'b1, "primary reference")
        for (int i = 0; i < 64; i++) begin
            rnd = lfsr(rnd);
            code = i[5:0];
            #1;
            pe = (code[4:0] inside {[5'h03:5'h09]}) ? code[4:0] : 5'h00;
            c1e = cl_x(code);
            c2e = cl_x(rnd[5:0]);
            me = (code inside {6'h08, [6'h0A:6'h10], 6'h14, 6'h18})
                ? code[4:0] : 5'h00;
            sde = (rnd[15:13] inside {[3'h1:3'h4]}) ? rnd[15:13] : 3'h0;
            wr(ccd_pkg::OFS_CFG_LO, lo);
            wr(ccd_pkg::OFS_CFG_HI, hi);
            chk_out();
            rd(ccd_pkg::OFS_RATIOS, {12'h000, pe, c1e, c2e, me},
               32'hFFFF_FFFF, ccd_pkg::RESP_OKAY);
        end
        for (int j = 0; j < 8; j++) begin
            prot = tp[j];
            div = tdv[j];
            rsel = trf[j];
            #1;
            wr(ccd_pkg::OFS_CFG_HI, hi);
            rd(ccd_pkg::OFS_SELECTS, {tex[j], 8'h00}, (j < 6) ? 32'hFFFF_FF00
               : 32'hFFFF_0000, ccd_pkg::RESP_OKAY);
        end
        rd(8'h3C, 32'h0, 32'hFFFF_FFFF, ccd_pkg::RESP_SLVERR);
        // Held configuration refuses a new word and keeps the old decode
        old = lo;
        wr(ccd_pkg::OFS_CTRL, 32'h0000_0001);
        code = 6'h0A;
        #1;
        wr(ccd_pkg::OFS_CFG_LO, lo);
        chk_out();
        rd(ccd_pkg::OFS_CFG_LO, old, 32'hFFFF_FFFF, ccd_pkg::RESP_OKAY);
        repeat (4) @(posedge mclk);
        end_of_test();
    end
endmodule
